// file: verilog/fbi_host.sv
`timescale 1ns/100ps
// Functional notes
// R1: falling select latches address, may start write
// R2: select high is standby; low, strobe high reads
// R3: strobe falling under select writes the byte
// R4: last falling signal decides write control
// R5: output gate only enables data drivers
// R6: select low 70ns, high 60ns, cycle 130ns
// R7: read data valid 70ns after select
// R8: read data valid 12ns after gate
// R9: data released 15ns after select rises
// R10: data released 15ns after gate rises
// R11: write strobe low at least 40ns
// R12: select low 70ns before strobe rises
// R13: device releases data 15ns after strobe falls
// R14: host frees bus within 10ns turnaround
// R15: wait 10ms after power before access
// R16: strobe high while power ramps
module fbi_host #(
	parameter longint POWERUP_CYC = fbi_pkg::POWERUP_WAIT_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// user request side
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [fbi_pkg::ADDR_W-1:0] req_addr_in,
	input wire logic [fbi_pkg::DATA_W-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [fbi_pkg::DATA_W-1:0] rsp_rdata_out,
	// memory pins
	output logic mem_sel_n_out,
	output logic mem_wr_n_out,
	output logic mem_gate_n_out,
	output logic [fbi_pkg::ADDR_W-1:0] mem_addr_out,
	input wire logic [fbi_pkg::DATA_W-1:0] mem_dq_in,
	output logic [fbi_pkg::DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe_n_out
);
	typedef enum logic [6:0] {
		FBI_PWRUP = 7'h01,
		FBI_IDLE = 7'h02,
		FBI_RD = 7'h04,
		FBI_WSET = 7'h08,
		FBI_WR = 7'h10,
		FBI_TURN = 7'h20,
		FBI_PRE = 7'h40
	} fbi_state_t;

	typedef struct packed {
		fbi_state_t state;
		logic [fbi_pkg::CNT_W-1:0] cnt;
		logic [fbi_pkg::CNT_W-1:0] cyc;
		logic sel_n;
		logic wr_n;
		logic gate_n;
		logic [fbi_pkg::ADDR_W-1:0] addr;
		logic [fbi_pkg::DATA_W-1:0] wdata;
		logic dq_oe_n;
		logic rsp_valid;
		logic [fbi_pkg::DATA_W-1:0] rdata;
	} fbi_host_st_t;

	// counter step
	localparam logic [fbi_pkg::CNT_W-1:0] ONE = 24'h000001;
	// last power-up count; the idle state follows on the next edge
	localparam logic [fbi_pkg::CNT_W-1:0] PWR_LAST = fbi_pkg::CNT_W'(POWERUP_CYC - 1);
	// read sample waits out access time plus the synchroniser delay
	localparam logic [fbi_pkg::CNT_W-1:0] RD_SAMPLE =
		fbi_pkg::CNT_W'(fbi_pkg::ACCESS_CYC + 2);
	// gate pin moves one edge after the count is seen, so start a cycle early;
	// gate access then ends before the pin sample instead of on top of it
	localparam logic [fbi_pkg::CNT_W-1:0] GATE_AT =
		fbi_pkg::CNT_W'(fbi_pkg::ACCESS_CYC - fbi_pkg::GATE_ACCESS_CYC - 1);
	// last count of the select-active minimum
	localparam logic [fbi_pkg::CNT_W-1:0] ACT_LAST =
		fbi_pkg::CNT_W'(fbi_pkg::SELECT_ACTIVE_CYC - 1);
	// full release time, counted from the edge on which the strobe falls
	localparam logic [fbi_pkg::CNT_W-1:0] RLS_AT =
		fbi_pkg::CNT_W'(fbi_pkg::RELEASE_CYC);
	// last count of the strobe pulse minimum
	localparam logic [fbi_pkg::CNT_W-1:0] WP_LAST =
		fbi_pkg::CNT_W'(fbi_pkg::STROBE_PULSE_CYC - 1);
	// cycle count is already one on the edge where select falls, so no minus one here
	localparam logic [fbi_pkg::CNT_W-1:0] CW_AT =
		fbi_pkg::CNT_W'(fbi_pkg::SELECT_TO_STROBE_CYC);
	// last counts of precharge and of the whole cycle
	localparam logic [fbi_pkg::CNT_W-1:0] PC_LAST =
		fbi_pkg::CNT_W'(fbi_pkg::PRECHARGE_CYC - 1);
	localparam logic [fbi_pkg::CNT_W-1:0] RC_LAST =
		fbi_pkg::CNT_W'(fbi_pkg::READ_CYCLE_CYC - 1);

	fbi_host_st_t st_q;
	fbi_host_st_t st_d;
	logic [fbi_pkg::DATA_W-1:0] dq_sync;

	// data pins are asynchronous to this clock; two flops before any use
	fbi_sync #(
		.W(fbi_pkg::DATA_W)
	) u_dq_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(mem_dq_in),
		.sync_out(dq_sync)
	);

	// sequencer: one access at a time, all pin timing counted in clocks
	always_comb begin
		st_d = st_q;
		st_d.rsp_valid = 1'b0;
		st_d.cnt = st_q.cnt + ONE;
		st_d.cyc = st_q.cyc + ONE;
		case (st_q.state)
			FBI_PWRUP: begin
				// strobes held high until supply has settled [R15] [R16]
				st_d.sel_n = 1'b1;
				st_d.wr_n = 1'b1;
				if (st_q.cnt >= PWR_LAST) begin
					st_d.state = FBI_IDLE;
				end
			end
			FBI_IDLE: begin
				st_d.cnt = '0;
				st_d.cyc = '0;
				if (req_valid_in) begin
					// address driven on the same edge as select falls, latched by it [R1]
					st_d.addr = req_addr_in;
					st_d.wdata = req_wdata_in;
					st_d.sel_n = 1'b0;
					st_d.cyc = ONE;
					if (req_write_in) begin
						// strobe falls after select: strobe-controlled write [R3] [R4]
						st_d.state = FBI_WSET;
					end else begin
						st_d.state = FBI_RD; // select low, strobe high reads [R2]
					end
				end
			end
			FBI_RD: begin
				// gate only drives the buffers; access already running [R5] [R8]
				if (st_q.cnt >= GATE_AT) begin
					st_d.gate_n = 1'b0;
				end
				// answer pulse and captured byte go out together
				if (st_q.cnt == RD_SAMPLE) begin
					st_d.rdata = dq_sync; // data valid 70ns after select [R7]
					st_d.rsp_valid = 1'b1;
				end
				if (st_q.cnt >= RD_SAMPLE && st_q.cnt >= ACT_LAST) begin
					st_d.sel_n = 1'b1; // select held at least 70ns [R6]
					st_d.gate_n = 1'b1;
					st_d.cnt = '0;
					st_d.state = FBI_PRE;
				end
			end
			FBI_WSET: begin
				// wait for device to release bus before driving it [R13]
				st_d.wr_n = 1'b0;
				if (st_q.cnt >= RLS_AT) begin
					st_d.dq_oe_n = 1'b0;
					st_d.cnt = '0;
					st_d.state = FBI_WR;
				end
			end
			FBI_WR: begin
				// strobe pulse and select-to-strobe-high minimums [R11] [R12]
				if (st_q.cnt >= WP_LAST && st_q.cyc >= CW_AT) begin
					st_d.wr_n = 1'b1;
					st_d.cnt = '0;
					st_d.state = FBI_TURN;
				end
			end
			FBI_TURN: begin
				// release bus one edge after strobe rise, inside the device turnaround [R14]
				st_d.dq_oe_n = 1'b1;
				st_d.sel_n = 1'b1;
				// one-cycle answer pulse marks the write as done
				st_d.rsp_valid = 1'b1;
				st_d.cnt = ONE;
				st_d.state = FBI_PRE;
			end
			FBI_PRE: begin
				// precharge and full cycle minimums before next select [R6] [R9] [R10]
				// a request arriving now waits; ready stays low until idle
				if (st_q.cnt >= PC_LAST && st_q.cyc >= RC_LAST) begin
					st_d.state = FBI_IDLE;
				end
			end
			default: begin
				// an illegal state falls back to power-up with every strobe parked high
				st_d.state = FBI_PWRUP;
				st_d.sel_n = 1'b1;
				st_d.wr_n = 1'b1;
				st_d.gate_n = 1'b1;
				st_d.dq_oe_n = 1'b1;
			end
		endcase
	end

	// reset parks every strobe high and the data bus released
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '{state: FBI_PWRUP, cnt: '0, cyc: '0, sel_n: 1'b1, wr_n: 1'b1,
				gate_n: 1'b1, addr: '0, wdata: '0, dq_oe_n: 1'b1, rsp_valid: 1'b0,
				rdata: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// strobes and data come straight from flops, so the pins never glitch
	assign req_ready_out = (st_q.state == FBI_IDLE);
	assign rsp_valid_out = st_q.rsp_valid;
	assign rsp_rdata_out = st_q.rdata;
	assign mem_sel_n_out = st_q.sel_n;
	assign mem_wr_n_out = st_q.wr_n;
	assign mem_gate_n_out = st_q.gate_n;
	assign mem_addr_out = st_q.addr;
	assign mem_dq_out = st_q.wdata;
	assign mem_dq_oe_n_out = st_q.dq_oe_n;
endmodule

// file: verilog/fbi_pkg.sv
package fbi_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	// bus timing in ns, power-up wait in ms, as printed
	localparam int SELECT_ACTIVE_MIN_NS = 70;
	localparam int PRECHARGE_MIN_NS = 60;
	localparam int READ_CYCLE_MIN_NS = 130;
	localparam int ACCESS_MAX_NS = 70;
	localparam int GATE_ACCESS_MAX_NS = 12;
	localparam int RELEASE_MAX_NS = 15;
	localparam int STROBE_PULSE_MIN_NS = 40;
	localparam int SELECT_TO_STROBE_HIGH_MIN_NS = 70;
	localparam int TURNAROUND_MIN_NS = 10;
	localparam int POWERUP_WAIT_MIN_MS = 10;
	// least times round up to whole cycles
	localparam int SELECT_ACTIVE_CYC = (SELECT_ACTIVE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int PRECHARGE_CYC = (PRECHARGE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int READ_CYCLE_CYC = (READ_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int STROBE_PULSE_CYC = (STROBE_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int SELECT_TO_STROBE_CYC =
		(SELECT_TO_STROBE_HIGH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// data sampled after access time plus two synchroniser stages
	localparam int ACCESS_CYC = (ACCESS_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GATE_ACCESS_CYC = (GATE_ACCESS_MAX_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int RELEASE_CYC = (RELEASE_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TURNAROUND_CYC = (TURNAROUND_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam longint POWERUP_WAIT_CYC = (longint'(POWERUP_WAIT_MIN_MS) * 1000000000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 24;
endpackage

// file: verilog/fbi_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for the data pins coming back from the memory
module fbi_sync #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fbi_sync_st_t;
	fbi_sync_st_t st_q;
	fbi_sync_st_t st_d;

	// first stage is read only by the second
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule

// file: sim/fbi_host_properties.sv
`timescale 1ns/100ps
// timing watch on the memory pins
module fbi_chk #(
	parameter longint POWERUP_CYC = 10
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_ready_out,
	input wire logic mem_sel_n_out,
	input wire logic mem_wr_n_out,
	input wire logic mem_gate_n_out,
	input wire logic mem_dq_oe_n_out
);
	logic [5:0] lo_q;
	logic [5:0] hi_q;
	logic [5:0] wl_q;
	logic [23:0] pu_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// run lengths; precharge preset so the first access after reset counts as rested
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lo_q <= 6'h00;
			hi_q <= 6'h0f;
			wl_q <= 6'h00;
			pu_q <= 24'h000000;
		end else begin
			lo_q <= mem_sel_n_out ? 6'h00 : lo_q + 6'h01;
			hi_q <= mem_sel_n_out ? hi_q + 6'(hi_q != 6'h3f) : 6'h00;
			wl_q <= mem_wr_n_out ? 6'h00 : wl_q + 6'h01;
			pu_q <= pu_q + 24'(pu_q != 24'hffffff);
		end
	end
	property p_sel_low;
		$rose(mem_sel_n_out) |-> lo_q >= 6'h12;
	endproperty
	property p_precharge;
		$fell(mem_sel_n_out) |-> hi_q >= 6'h0f;
	endproperty
	property p_strobe;
		$rose(mem_wr_n_out) |-> wl_q >= 6'h0a;
	endproperty
	property p_sel_strobe;
		$rose(mem_wr_n_out) |-> !mem_sel_n_out && lo_q >= 6'h12;
	endproperty
	property p_last_low;
		$fell(mem_wr_n_out) |-> !mem_sel_n_out && !$past(mem_sel_n_out);
	endproperty
	property p_turn;
		$rose(mem_wr_n_out) |-> ##[0:2] mem_dq_oe_n_out;
	endproperty
	property p_powerup;
		pu_q < POWERUP_CYC - 1 |-> mem_sel_n_out && !req_ready_out;
	endproperty
	property p_ramp;
		pu_q < POWERUP_CYC - 1 |-> mem_wr_n_out;
	endproperty
	// gate only inside a read: select low, strobe high
	property p_gate_read;
		!mem_gate_n_out |-> !mem_sel_n_out && mem_wr_n_out;
	endproperty
	// host drives data only under select with the gate off
	property p_bus_write;
		!mem_dq_oe_n_out |-> !mem_sel_n_out && mem_gate_n_out;
	endproperty
	// host waits the full release time after the strobe falls
	property p_release;
		$fell(mem_dq_oe_n_out) |-> wl_q >= 6'h04;
	endproperty
	// gate by 60 ns after select so its access ends before the 76 ns sample
	property p_gate_early;
		$fell(mem_gate_n_out) |-> lo_q <= 6'h0f;
	endproperty
	a_sel_low: assert property (p_sel_low) else $error("select low too short");
	a_precharge: assert property (p_precharge) else $error("precharge too short");
	a_strobe: assert property (p_strobe) else $error("strobe too short");
	a_sel_strobe: assert property (p_sel_strobe) else $error("strobe rose early");
	a_last_low: assert property (p_last_low) else $error("strobe not last");
	a_turn: assert property (p_turn) else $error("bus held too long");
	a_powerup: assert property (p_powerup) else $error("access in power-up");
	a_ramp: assert property (p_ramp) else $error("strobe low in power-up");
	a_gate_read: assert property (p_gate_read) else $error("gate outside read");
	a_bus_write: assert property (p_bus_write) else $error("bus driven with gate");
	a_release: assert property (p_release) else $error("bus driven too soon");
	a_gate_early: assert property (p_gate_early) else $error("gate too late");
	c_write: cover property ($rose(mem_wr_n_out));
	c_access: cover property ($rose(mem_sel_n_out));
	c_ready: cover property ($rose(req_ready_out));
	c_read: cover property ($fell(mem_gate_n_out));
endmodule
bind fbi_host fbi_chk #(.POWERUP_CYC(POWERUP_CYC)) chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.req_ready_out(req_ready_out), .mem_sel_n_out(mem_sel_n_out),
	.mem_wr_n_out(mem_wr_n_out), .mem_gate_n_out(mem_gate_n_out),
	.mem_dq_oe_n_out(mem_dq_oe_n_out));

// file: sim/fbi_mem_model.sv
`timescale 1ns/100ps
// behavioural memory at the slowest legal timing
module fbi_mem (
	input wire logic sel_n_in,
	input wire logic wr_n_in,
	input wire logic gate_n_in,
	input wire logic [12:0] addr_in,
	input wire logic [7:0] host_dq_in,
	input wire logic host_oe_n_in,
	output logic [7:0] dq_out
);
	logic [7:0] mem_q [8192];
	logic [12:0] addr_q;
	logic acc = 1'b0;
	logic drv = 1'b0;
	// latch on select fall; data comes late, at the access limit
	// address and select move in one step; read the address just after
	always @(negedge sel_n_in) begin
		acc = 1'b0;
		acc <= #70 1'b1;
		#0.1 addr_q = addr_in;
	end
	// drivers follow the gate in reads only; release as late as allowed
	always @(sel_n_in or wr_n_in or gate_n_in) begin
		if (sel_n_in || !wr_n_in || gate_n_in)
			drv <= #15 1'b0;
		else
			drv <= #12 1'b1;
	end
	// store on whichever edge ends the write
	always @(posedge wr_n_in or posedge sel_n_in) begin
		if (!sel_n_in || !wr_n_in)
			mem_q[addr_q] = host_dq_in;
	end
	// no pull on the bus: undriven shows the inverse so a stale sample fails
	assign dq_out = !host_oe_n_in ? host_dq_in : (drv && acc) ? mem_q[addr_q] : ~mem_q[addr_q];
endmodule

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clk_in = 1'b0;
	logic rst_n = 1'b0;
	logic valid = 1'b0;
	logic wr = 1'b0;
	logic [12:0] addr = 13'h0000;
	logic [7:0] wdata = 8'h00;
	logic ready, rsp, sel_n, wr_n, gate_n, oe_n;
	logic [7:0] rdata, dq_o, dq_i;
	logic [12:0] maddr;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	fbi_host #(.POWERUP_CYC(10)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n),
		.req_valid_in(valid), .req_write_in(wr), .req_addr_in(addr), .req_wdata_in(wdata),
		.req_ready_out(ready), .rsp_valid_out(rsp), .rsp_rdata_out(rdata),
		.mem_sel_n_out(sel_n), .mem_wr_n_out(wr_n), .mem_gate_n_out(gate_n),
		.mem_addr_out(maddr), .mem_dq_in(dq_i), .mem_dq_out(dq_o), .mem_dq_oe_n_out(oe_n));
	fbi_mem mem_u (.sel_n_in(sel_n), .wr_n_in(wr_n), .gate_n_in(gate_n), .addr_in(maddr),
		.host_dq_in(dq_o), .host_oe_n_in(oe_n), .dq_out(dq_i));
	task close_out;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one request, issued only while idle; waits for the answer pulse
	task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
		int n = 0;
		do @(negedge clk_in); while (ready !== 1'b1 && ++n < 100);
		chk({7'h00, ready}, 8'h01);
		@(posedge clk_in);
		valid <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		valid <= 1'b0;
		n = 0;
		do @(negedge clk_in); while (rsp !== 1'b1 && ++n < 100);
		chk({7'h00, rsp}, 8'h01);
		q = rdata;
	endtask
	// reset for ten cycles, then no access during the power-up wait
	task automatic t_power;
		@(posedge clk_in);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk_in);
		rst_n <= 1'b1;
		repeat (8) begin
			@(negedge clk_in);
			chk({7'h00, ready}, 8'h00);
		end
	endtask
	// back-to-back writes at both address ends, then read each back
	task automatic t_wr_rd;
		logic [7:0] q;
		logic [12:0] a [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
		for (int i = 0; i < 3; i++)
			op(1'b1, a[i], a[i][7:0] ^ 8'h5a, q);
		for (int i = 0; i < 3; i++) begin
			op(1'b0, a[i], 8'h00, q);
			chk(q, a[i][7:0] ^ 8'h5a);
		end
	endtask
	// contents survive a second reset and power-up of the host
	task automatic t_keep;
		logic [7:0] q;
		op(1'b0, 13'h1fff, 8'h00, q);
		chk(q, 8'ha5);
	endtask
	// cycle ceiling covers two power-ups and a handful of accesses
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		t_power;
		t_wr_rd;
		t_power;
		t_keep;
		close_out;
	end
endmodule
